/* dv/srg_flyback_model.sv */
// partner: flyback secondary switch and sense network seen by the gate core
module srg_flyback_model (
  input  wire logic clk,            // core clock
  input  wire logic rect_gate_cmd,  // gate command from the core
  output logic      sync_input,     // high while primary conducts
  output logic      revAboveThresh  // sense above threshold
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    sync_input = 1'b1;
    revAboveThresh = 1'b1;
  end

  // ----------------------------------------
  // one switching period
  // ----------------------------------------
  // revAt: off cycle at which sense rises; 0 = never falls, -1 = stays low
  task automatic run(input int onC, input int offC, input int revAt,
                     output int hi, output int tail);
    hi = 0;
    tail = 0;
    repeat (onC) @(posedge clk);
    #2;
    sync_input = 1'b0;
    // blanking pulls sense low at turn-off unless revAt is 0, masking ringing
    revAboveThresh = (revAt == 0);
    for (int k = 1; k <= offC; k++) begin
      @(posedge clk);
      #1;
      hi += (rect_gate_cmd === 1'b1);
      tail = (rect_gate_cmd === 1'b0) ? tail + 1 : 0;
      #1;
      if (k == revAt) begin
        revAboveThresh = 1'b1;
      end
    end
    sync_input = 1'b1;
    revAboveThresh = 1'b1;
  endtask
endmodule // srg_flyback_model

/* dv/testbench.sv */
// testbench: self-checking bench for the rectifier gate timing core
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import srg_pkg::*;

  logic        clk;
  logic        sys_rst;
  srg_ant_t    antSel;
  logic        syncIn;
  logic        revAbove;
  logic        gateCmd;
  logic        lightLoad;
  int          failures;
  int          checks_done;
  logic [31:0] rngState;
  int          hi;
  int          tail;
  int          prevP;
  int          onC;
  int          p;
  int          a;
  int          e;

  srg_gate_timing i_srg_gate_timing (
    .clk(clk), .sys_rst(sys_rst), .sync_input(syncIn), .revAboveThresh(revAbove),
    .early_off_select(antSel), .rect_gate_cmd(gateCmd), .lightLoad(lightLoad));

  srg_flyback_model i_srg_flyback_model (
    .clk(clk), .rect_gate_cmd(gateCmd), .sync_input(syncIn), .revAboveThresh(revAbove));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic int rnd(input int lo, input int up);
    rngState ^= rngState << 13;
    rngState ^= rngState >> 17;
    rngState ^= rngState << 5;
    return lo + int'(rngState % 32'(up - lo + 1));
  endfunction

  function automatic int ant_cyc(input srg_ant_t s);
    return (s == SRG_ANT_LOW) ? ANT_LOW_CYC : (s == SRG_ANT_MID) ? ANT_MID_CYC : ANT_HIGH_CYC;
  endfunction

  task automatic chk_range(input string what, input int lo, input int up, input int seen);
    checks_done++;
    if (seen < lo || seen > up) begin
      failures++;
      $display("[ERR] %s expected %0d..%0d seen %0d", what, lo, up, seen);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic seen);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %b seen %b", what, exp, seen);
    end
  endtask

  task automatic per(input int onC, input int offC, input int revAt);
    i_srg_flyback_model.run(onC, offC, revAt, hi, tail);
  endtask

  task automatic test_done();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // about 2700 cycles expected; cut off well beyond
  initial begin
    #(20000 * 50);
    failures++;
    test_done();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    failures = 0;
    checks_done = 0;
    rngState = 32'h4623;
    sys_rst = 1'b1;
    antSel = SRG_ANT_LOW;
    repeat (2) @(posedge clk);
    #2 sys_rst = 1'b0;
    chk_bit("gate after reset", 1'b0, gateCmd);
    for (int s = 0; s < 3; s++) begin
      antSel = srg_ant_t'(s);
      a = ant_cyc(antSel);
      for (int n = 0; n < 4; n++) begin
        per(16, 24, -1);
        if (n > 1) begin
          chk_range("anticipation", (a > 1) ? a - 1 : 1, a + 1, tail);
          chk_bit("gate active", 1'b1, hi > 0);
        end
      end
      $display("test anticipation select %0d done", s);
    end
    // turn-off point follows the last measured period; every fifth an 80% duty jump
    prevP = 40;
    for (int n = 0; n < 30; n++) begin
      p = (n % 5 == 4) ? prevP : rnd(38, 46);
      onC = (n % 5 == 4) ? p * 8 / 10 : p * rnd(30, 60) / 100;
      per(onC, p - onC, -1);
      e = a + p - prevP;
      chk_range("period tail", (e > 1) ? e - 1 : 0, (e > 0) ? e + 1 : 1, tail);
      prevP = p;
    end
    $display("test random periods done");
    per(16, 24, -1);
    for (int r = 3; r <= 15; r += 4) begin
      per(16, 24, r);
      chk_range("inhibit high time", r - 1, r, hi);
    end
    per(16, 24, 0);
    chk_range("inhibit at start", 0, 1, hi);
    $display("test inhibit done");
    repeat (4) per(5, 45, -1);
    chk_bit("light load entry", 1'b1, lightLoad);
    chk_range("gate idle light load", 0, 0, hi);
    repeat (3) per(8, 42, -1);
    chk_bit("hysteresis hold", 1'b1, lightLoad);
    chk_range("gate idle hysteresis", 0, 0, hi);
    repeat (3) per(12, 38, -1);
    chk_bit("light load exit", 1'b0, lightLoad);
    chk_range("gate resumes", 1, 38, hi);
    $display("test light load done");
    per(12, 200, -1);
    chk_range("hold low tail", 150, 200, tail);
    $display("test hold low done");
    test_done();
  end
endmodule // testbench

/* hdl/srg_gate_timing.sv */
// module: synchronous rectifier gate timing core
// What this block does
// - gate on at falling edge of sync_input
// - sense 250ns window, drop gate if above threshold
// - hold gate while below threshold, then drop
// - gate off 50/150/200ns (1/3/4 clocks) before next turn-on
// - anticipation timed by counting oscillator pulses
// - turn-off point from period, not duty cycle
// - duty below 14% holds gate off, shutdown
// - resume only when duty exceeds 18%
// - sync held low keeps gate off
module srg_gate_timing
  import srg_pkg::*;
(
  input  wire logic              clk,              // 20 MHz clock
  input  wire logic              sys_rst,          // async reset, high
  input  wire logic              sync_input,       // high while primary conducts
  input  wire logic              revAboveThresh,   // comparator: sense above -25mV
  input  wire srg_pkg::srg_ant_t early_off_select, // anticipation third
  output logic                   rect_gate_cmd,    // rectifier gate command
  output logic                   lightLoad         // shutdown state flag
);
  // ----------------------------------------------------------------
  // edge detection
  // ----------------------------------------------------------------
  logic syncQ;
  logic syncRise;
  logic syncFall;
  assign syncRise = sync_input & ~syncQ;
  assign syncFall = ~sync_input & syncQ;

  srg_meas_t        meas;
  logic             measValid;
  logic [CNT_W-1:0] elapsed;

  srg_period_meter u_meter (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .syncRise  (syncRise),
    .syncFall  (syncFall),
    .meas      (meas),
    .measValid (measValid),
    .elapsed   (elapsed)
  );

  function automatic logic [CNT_W-1:0] antCycles(input srg_ant_t sel);
    case (sel)
      SRG_ANT_LOW:  antCycles = CNT_W'(ANT_LOW_CYC);
      SRG_ANT_MID:  antCycles = CNT_W'(ANT_MID_CYC);
      SRG_ANT_HIGH: antCycles = CNT_W'(ANT_HIGH_CYC);
      default:      antCycles = CNT_W'(ANT_HIGH_CYC);
    endcase
  endfunction

  // ----------------------------------------------------------------
  // duty-cycle hysteresis
  // ----------------------------------------------------------------
  // compare onTime*100 against period*pct; 32 bits avoids overflow
  logic [31:0] onScaled;
  logic [31:0] offLimit;
  logic [31:0] onLimit;
  logic        next_lightLoad;
  assign onScaled = 32'(meas.onTime) * 32'd100;
  assign offLimit = 32'(meas.period) * 32'(DUTY_OFF_PCT);
  assign onLimit  = 32'(meas.period) * 32'(DUTY_ON_PCT);

  logic measSeen;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      measSeen <= 1'b0;
    end else begin
      measSeen <= measValid;
    end
  end

  always_comb begin
    next_lightLoad = lightLoad;
    if (measSeen) begin
      if (!lightLoad && onScaled < offLimit) begin
        next_lightLoad = 1'b1;
      end else if (lightLoad && onScaled > onLimit) begin
        next_lightLoad = 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // gate state machine
  // ----------------------------------------------------------------
  srg_state_t       state;
  srg_state_t       next_state;
  logic [3:0]       winCnt;
  logic [3:0]       next_winCnt;
  logic             next_gate;
  logic [CNT_W-1:0] offPoint;
  logic [CNT_W-1:0] ant;

  // turn-off point uses the period only, so duty steps do not move it
  assign ant      = antCycles(early_off_select);
  assign offPoint = (meas.period > ant) ? meas.period - ant : '0;

  always_comb begin
    next_state  = state;
    next_winCnt = winCnt;
    next_gate   = 1'b0;
    case (state)
      SRG_ST_IDLE: begin
        if (syncFall && !lightLoad) begin
          next_state  = SRG_ST_BLANK;
          next_winCnt = 4'(SENSE_CYC);
          next_gate   = 1'b1;
        end
      end
      SRG_ST_BLANK: begin
        next_gate   = 1'b1;
        next_winCnt = winCnt - 4'h1;
        // a short off time can reach the turn-off point inside the window
        if (revAboveThresh || elapsed >= offPoint) begin
          next_state = SRG_ST_IDLE;
          next_gate  = 1'b0;
        end else if (winCnt == 4'h1) begin
          next_state = SRG_ST_COND;
        end
      end
      SRG_ST_COND: begin
        next_gate = 1'b1;
        if (revAboveThresh || elapsed >= offPoint) begin
          next_state = SRG_ST_IDLE;
          next_gate  = 1'b0;
        end
      end
      default: begin
        next_state = SRG_ST_IDLE;
      end
    endcase
    // rising sync means primary conducts; held-low sync never falls again
    if (sync_input || lightLoad) begin
      next_state = SRG_ST_IDLE;
      next_gate  = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      syncQ         <= 1'b0;
      state         <= SRG_ST_IDLE;
      winCnt        <= 4'h0;
      rect_gate_cmd <= 1'b0;
      lightLoad     <= 1'b0;
    end else begin
      syncQ         <= sync_input;
      state         <= next_state;
      winCnt        <= next_winCnt;
      rect_gate_cmd <= next_gate;
      lightLoad     <= next_lightLoad;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_fallOk;
    syncFall && !lightLoad && state == SRG_ST_IDLE;
  endsequence

  property p_gateOnFall;
    @(posedge clk) disable iff (sys_rst) s_fallOk |=> rect_gate_cmd;
  endproperty
  a_gateOnFall: assert property (p_gateOnFall) else $error("gate not set on fall");

  property p_inhibitDrop;
    @(posedge clk) disable iff (sys_rst)
      (rect_gate_cmd && revAboveThresh) |=> !rect_gate_cmd;
  endproperty
  a_inhibitDrop: assert property (p_inhibitDrop) else $error("gate held above thresh");

  property p_holdBelow;
    @(posedge clk) disable iff (sys_rst)
      (state == SRG_ST_COND && !revAboveThresh && !sync_input && !lightLoad
       && elapsed < offPoint) |=> rect_gate_cmd;
  endproperty
  a_holdBelow: assert property (p_holdBelow) else $error("gate dropped early");

  property p_antOff;
    @(posedge clk) disable iff (sys_rst)
      (state == SRG_ST_COND && elapsed >= offPoint) |=> !rect_gate_cmd;
  endproperty
  a_antOff: assert property (p_antOff) else $error("anticipation missed");

  property p_offPoint;
    @(posedge clk) disable iff (sys_rst)
      (rect_gate_cmd && elapsed >= offPoint) |=> !rect_gate_cmd;
  endproperty
  a_offPoint: assert property (p_offPoint) else $error("off point wrong");

  property p_lightOff;
    @(posedge clk) disable iff (sys_rst) lightLoad |=> !rect_gate_cmd;
  endproperty
  a_lightOff: assert property (p_lightOff) else $error("gate on in light load");

  property p_resume;
    @(posedge clk) disable iff (sys_rst)
      $fell(lightLoad) |-> $past(onScaled) > $past(onLimit);
  endproperty
  a_resume: assert property (p_resume) else $error("resumed below 18pct");

  property p_syncLow;
    @(posedge clk) disable iff (sys_rst)
      (!sync_input && !syncQ && state == SRG_ST_IDLE) [*2] |-> !rect_gate_cmd;
  endproperty
  a_syncLow: assert property (p_syncLow) else $error("gate on with sync low");

  property p_measure;
    @(posedge clk) disable iff (sys_rst) syncRise |=> measValid && meas.period == $past(elapsed);
  endproperty
  a_measure: assert property (p_measure) else $error("period not captured");
endmodule // srg_gate_timing

/* hdl/srg_period_meter.sv */
// module: measures switching period and primary on time in clock counts
module srg_period_meter
  import srg_pkg::*;
(
  input  wire logic                  clk,       // 20 MHz clock
  input  wire logic                  sys_rst,   // async reset, high
  input  wire logic                  syncRise,  // rising edge of sync_input
  input  wire logic                  syncFall,  // falling edge of sync_input
  output srg_pkg::srg_meas_t         meas,      // last full period result
  output logic                       measValid, // pulse: new result
  output logic [srg_pkg::CNT_W-1:0]  elapsed    // counts since last rise
);
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [CNT_W-1:0] hiCnt;
  logic [CNT_W-1:0] next_hiCnt;
  srg_meas_t        next_meas;
  logic             next_measValid;

  // saturating counters so a stalled sync does not wrap into a short period
  always_comb begin
    next_cnt       = (cnt == CNT_MAX) ? cnt : cnt + 16'h0001;
    next_hiCnt     = hiCnt;
    next_meas      = meas;
    next_measValid = 1'b0;
    if (syncFall) begin
      next_hiCnt = cnt;
    end
    if (syncRise) begin
      next_meas.period = cnt;
      next_meas.onTime = hiCnt;
      next_measValid   = 1'b1;
      next_cnt         = 16'h0001;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt       <= '0;
      hiCnt     <= '0;
      meas      <= '0;
      measValid <= 1'b0;
    end else begin
      cnt       <= next_cnt;
      hiCnt     <= next_hiCnt;
      meas      <= next_meas;
      measValid <= next_measValid;
    end
  end

  assign elapsed = cnt;
endmodule // srg_period_meter

/* hdl/srg_pkg.sv */
// package: constants and carrier types for the rectifier gate timing core
package srg_pkg;
  // clock 20 MHz
  localparam int CLK_PERIOD_NS   = 50;
  // reverse-current sampling window after gate assertion
  localparam int SENSE_WINDOW_NS = 250;
  localparam int SENSE_CYC       = (SENSE_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // anticipation intervals, all rounded down to whole clocks, minimum one
  localparam int ANT_LOW_NS      = 75;
  localparam int ANT_MID_NS      = 150;
  localparam int ANT_HIGH_NS     = 225;
  localparam int ANT_LOW_CYC     = (ANT_LOW_NS / CLK_PERIOD_NS) < 1 ? 1 : ANT_LOW_NS / CLK_PERIOD_NS;
  localparam int ANT_MID_CYC     = ANT_MID_NS / CLK_PERIOD_NS;
  localparam int ANT_HIGH_CYC    = ANT_HIGH_NS / CLK_PERIOD_NS;
  // duty-cycle thresholds in percent
  localparam int DUTY_OFF_PCT    = 14;
  localparam int DUTY_ON_PCT     = 18;
  localparam int CNT_W           = 16;
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;

  // early_off_select thirds of supply
  typedef enum logic [1:0] {
    SRG_ANT_LOW  = 2'b00,
    SRG_ANT_MID  = 2'b01,
    SRG_ANT_HIGH = 2'b10
  } srg_ant_t;

  typedef enum logic [1:0] {
    SRG_ST_IDLE  = 2'b00,
    SRG_ST_BLANK = 2'b01,
    SRG_ST_COND  = 2'b10
  } srg_state_t;

  // result of one completed switching period
  typedef struct packed {
    logic [CNT_W-1:0] period;
    logic [CNT_W-1:0] onTime;
  } srg_meas_t;
endpackage
